/* File: timer0_top.sv */
// 8-bit timer/counter with one compare unit behind an ahb-lite slave
// assumes single-word transfers; slave never inserts wait states
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ns
module timer0_top (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pins
  input  wire logic        external_count_input,
  output logic             compare_output_pin,
  output logic             compare_output_en,
  // interrupt
  input  wire logic        compare_irq_ack,
  output logic             irq,
  // count extremes
  output logic             count_at_bottom,
  output logic             count_at_max
);
  import timer0_pkg::*;

  // ==========================================================================
  // state
  ctrl_t       ctrl_r,     ctrl_nxt;
  logic [7:0]  count_r,    count_nxt;
  logic [7:0]  cmp_buf_r,  cmp_buf_nxt;
  logic [7:0]  cmp_act_r,  cmp_act_nxt;
  flags_t      flags_r,    flags_nxt;
  flags_t      mask_r,     mask_nxt;
  dir_t        dir_r,      dir_nxt;
  logic        block_r,    block_nxt;
  logic        wave_r,     wave_nxt;
  logic        wr_en_r,    wr_en_nxt;
  logic [7:0]  addr_r,     addr_nxt;
  logic [31:0] rdata_r,    rdata_nxt;

  logic [PRESCALE_W-1:0] prescale_cnt;
  logic                  tick;
  logic                  addr_phase;
  logic                  wr_ctrl;
  logic                  wr_count;
  logic                  wr_cmp;
  logic                  wr_flags;
  logic                  wr_mask;
  logic                  force_cmp;
  logic                  match;
  logic                  match_hit;
  logic                  pwm_mode;
  logic                  at_top;
  flags_t                flag_set;
  flags_t                flag_clr;
  ctrl_t                 ctrl_wr;

  // ==========================================================================
  // clock source
  timer0_prescaler #(
    .WIDTH (PRESCALE_W)
  ) u_prescaler (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .prescale_cnt (prescale_cnt)
  );

  timer0_clock_select #(
    .WIDTH (PRESCALE_W)
  ) u_clock_select (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .cs                   (ctrl_r.cs),
    .prescale_cnt         (prescale_cnt),
    .external_count_input (external_count_input),
    .timer_tick_clock     (tick)
  );

  // ==========================================================================
  // bus decode
  assign addr_phase = hsel & hready & htrans[1];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = rdata_r;

  always_comb begin
    wr_en_nxt = addr_phase & hwrite;
    addr_nxt  = addr_phase ? haddr[7:0] : addr_r;
    rdata_nxt = rdata_r;
    if (addr_phase && !hwrite) begin
      // unmapped offsets read as zero
      rdata_nxt = 32'h0000_0000;
      unique case (haddr[7:0])
        OFS_CTRL:    rdata_nxt[CTRL_W-1:0] = ctrl_r;
        OFS_COUNT:   rdata_nxt[7:0] = count_r;
        OFS_COMPARE: rdata_nxt[7:0] = cmp_buf_r;
        OFS_FLAGS:   rdata_nxt[1:0] = flags_r;
        OFS_MASK:    rdata_nxt[1:0] = mask_r;
        default:     rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_en_r <= 1'b0;
      addr_r  <= 8'h00;
      rdata_r <= 32'h0000_0000;
    end else begin
      wr_en_r <= wr_en_nxt;
      addr_r  <= addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign wr_ctrl  = wr_en_r & (addr_r == OFS_CTRL);
  assign wr_count = wr_en_r & (addr_r == OFS_COUNT);
  assign wr_cmp   = wr_en_r & (addr_r == OFS_COMPARE);
  assign wr_flags = wr_en_r & (addr_r == OFS_FLAGS);
  assign wr_mask  = wr_en_r & (addr_r == OFS_MASK);

  // ==========================================================================
  // control and compare registers
  assign pwm_mode = (ctrl_r.wgm == WM_PHASE_PWM) ||
                    (ctrl_r.wgm == WM_FAST_PWM);
  assign at_top   = tick && (count_r == COUNT_MAX) &&
                    (ctrl_r.wgm == WM_FAST_PWM ||
                     (ctrl_r.wgm == WM_PHASE_PWM && dir_r == DIR_UP));
  // force is a strobe: honoured in non-pwm modes only, never stored
  assign force_cmp = wr_ctrl && hwdata[FORCE_BIT] && !pwm_mode;
  // the control word as written, for the force strobe that rides with it
  assign ctrl_wr   = ctrl_t'(hwdata[CTRL_W-1:0]);

  always_comb begin
    ctrl_nxt    = wr_ctrl ? ctrl_wr : ctrl_r;
    mask_nxt    = wr_mask ? flags_t'(hwdata[1:0]) : mask_r;
    cmp_buf_nxt = wr_cmp ? hwdata[7:0] : cmp_buf_r;
    cmp_act_nxt = cmp_act_r;
    // pwm modes pick up the buffer only at top, to keep periods whole
    if (!pwm_mode) begin
      cmp_act_nxt = cmp_buf_nxt;
    end else if (at_top) begin
      cmp_act_nxt = cmp_buf_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r    <= CTRL_RST;
      mask_r    <= MASK_RST;
      cmp_buf_r <= CMP_RST;
      cmp_act_r <= CMP_RST;
    end else begin
      ctrl_r    <= ctrl_nxt;
      mask_r    <= mask_nxt;
      cmp_buf_r <= cmp_buf_nxt;
      cmp_act_r <= cmp_act_nxt;
    end
  end

  // ==========================================================================
  // counter unit
  assign count_at_bottom = (count_r == COUNT_BOT);
  assign count_at_max    = (count_r == COUNT_MAX);
  assign match           = (count_r == cmp_act_r);
  // a count write masks the match seen on the following tick
  assign match_hit       = tick && match && !block_r;

  always_comb begin
    count_nxt = count_r;
    dir_nxt   = dir_r;
    if (tick) begin
      unique case (ctrl_r.wgm)
        WM_CTC: begin
          // top is the compare value
          count_nxt = match ? COUNT_BOT : count_r + 8'h01;
        end
        WM_PHASE_PWM: begin
          unique case (dir_r)
            DIR_UP: begin
              if (count_at_max) begin
                dir_nxt   = DIR_DOWN;
                count_nxt = count_r - 8'h01;
              end else begin
                count_nxt = count_r + 8'h01;
              end
            end
            DIR_DOWN: begin
              if (count_at_bottom) begin
                dir_nxt   = DIR_UP;
                count_nxt = count_r + 8'h01;
              end else begin
                count_nxt = count_r - 8'h01;
              end
            end
            default: begin
              dir_nxt = DIR_UP;
            end
          endcase
        end
        default: begin
          count_nxt = count_r + 8'h01;
        end
      endcase
    end
    if (ctrl_r.wgm != WM_PHASE_PWM) begin
      dir_nxt = DIR_UP;
    end
    if (wr_count) begin
      count_nxt = hwdata[7:0];
    end
    block_nxt = wr_count ? 1'b1 : (tick ? 1'b0 : block_r);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= COUNT_RST;
      dir_r   <= DIR_UP;
      block_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      dir_r   <= dir_nxt;
      block_r <= block_nxt;
    end
  end

  // ==========================================================================
  // flags and interrupt
  always_comb begin
    flag_set.cmp = match_hit;
    unique case (ctrl_r.wgm)
      WM_PHASE_PWM: flag_set.ovf = tick && dir_r == DIR_DOWN &&
                                   count_at_bottom;
      default:      flag_set.ovf = tick && count_at_max;
    endcase
    flag_clr     = wr_flags ? flags_t'(hwdata[1:0]) : flags_t'(2'h0);
    flag_clr.cmp = flag_clr.cmp | compare_irq_ack;
    // a set in the same cycle as a clear wins
    flags_nxt    = (flags_r & ~flag_clr) | flag_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= FLAG_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign irq = |(flags_r & mask_r);

  // ==========================================================================
  // waveform generator
  assign compare_output_pin = wave_r;
  assign compare_output_en  = (ctrl_r.com != 2'h0);

  // non-pwm pin action of the com bits: 1 toggles, 2 clears, 3 sets
  function automatic logic com_action(input logic [1:0] com,
                                      input logic       cur);
    logic res;
    case (com)
      2'h1:    res = ~cur;
      2'h2:    res = 1'b0;
      2'h3:    res = 1'b1;
      default: res = cur;
    endcase
    return res;
  endfunction

  always_comb begin
    wave_nxt = wave_r;
    unique case (ctrl_r.wgm)
      WM_FAST_PWM: begin
        // com 1 is reserved here and does nothing
        if (ctrl_r.com[1] && match_hit) begin
          wave_nxt = ctrl_r.com[0];
        end else if (ctrl_r.com[1] && at_top) begin
          wave_nxt = ~ctrl_r.com[0];
        end
      end
      WM_PHASE_PWM: begin
        if (ctrl_r.com[1] && match_hit) begin
          wave_nxt = (dir_r == DIR_UP) ? ctrl_r.com[0] : ~ctrl_r.com[0];
        end
      end
      default: begin
        // a forced match acts at once, so it uses the com bits written
        // with it; the stored com bits only land on the same edge
        if (force_cmp) begin
          wave_nxt = com_action(ctrl_wr.com, wave_r);
        end else if (match_hit) begin
          wave_nxt = com_action(ctrl_r.com, wave_r);
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_r <= 1'b0;
    end else begin
      wave_r <= wave_nxt;
    end
  end
endmodule

/* File: timer0_pkg.sv */
// constants, field layouts and carrier types of the 8-bit timer block
// assumes an ahb-lite slave with word-aligned registers, one clock (hclk)
// Operation
// - count and compare registers are eight bits wide and reachable by software
// - every timer interrupt request shows as a bit in the flag register
// - each request has its own mask bit, independent of the others
// - counter advances from prescaled internal clock or external event input
// - clock select picks the source and the active edge, giving the tick
// - with no source selected the counter holds its value
// - compare value is compared with the count at all times
// - compare result drives a pwm or frequency waveform on the output pin
// - a compare match sets the match flag, which can raise an interrupt
// - bottom is signalled when the count becomes 0x00
// - a count of 0xff is the maximum
// - top is 0xff or the compare register, chosen by the mode
// - the prescaler is ten bits wide
// - a software write to the count beats any clear or count that tick
// - the match flag is set on the tick after the matching count
// - match flag clears on interrupt service, or by writing one to it
// - overflow flag is set at a mode-dependent point and can interrupt
package timer0_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_COUNT   = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_FLAGS   = 8'h0c;
  localparam logic [7:0] OFS_MASK    = 8'h10;

  // ==========================================================================
  // field positions
  localparam int FORCE_BIT = 7;
  localparam int CTRL_W    = 7;
  localparam int OVF_BIT   = 0;
  localparam int CMP_BIT   = 1;

  // ==========================================================================
  // values and widths
  localparam int         PRESCALE_W = 10;
  localparam logic [7:0] COUNT_MAX  = 8'hff;
  localparam logic [7:0] COUNT_BOT  = 8'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] CMP_RST    = 8'h00;
  localparam logic [1:0] FLAG_RST   = 2'h0;
  localparam logic [1:0] MASK_RST   = 2'h0;

  // ==========================================================================
  // encodings
  typedef enum logic [2:0] {
    CS_STOP  = 3'h0,
    CS_DIV1  = 3'h1,
    CS_DIV8  = 3'h2,
    CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1024 = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } clk_src_t;

  typedef enum logic [1:0] {
    WM_NORMAL    = 2'h0,
    WM_PHASE_PWM = 2'h1,
    WM_CTC       = 2'h2,
    WM_FAST_PWM  = 2'h3
  } wave_mode_t;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } dir_t;

  // bit layout matches the control register: [6:5] com, [4:3] mode, [2:0] cs
  typedef struct packed {
    logic [1:0] com;
    wave_mode_t wgm;
    clk_src_t   cs;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{com: 2'h0, wgm: WM_NORMAL, cs: CS_STOP};

  typedef struct packed {
    logic cmp;
    logic ovf;
  } flags_t;

endpackage

/* File: timer0_prescaler.sv */
// free-running prescaler counter shared by the internal clock taps
// assumes hclk is the system clock; counter runs on every rising edge
`timescale 1ns/1ns
module timer0_prescaler #(
  parameter int WIDTH = timer0_pkg::PRESCALE_W
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // count
  output logic [WIDTH-1:0]      prescale_cnt
);
  import timer0_pkg::*;

  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r + WIDTH'(1);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign prescale_cnt = cnt_r;
endmodule

/* File: timer0_clock_select.sv */
// picks the timer tick from prescaler taps or edges of the event input
// assumes the event input is already synchronous to hclk
`timescale 1ns/1ns
module timer0_clock_select #(
  parameter int WIDTH = timer0_pkg::PRESCALE_W
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // selection and sources
  input  wire timer0_pkg::clk_src_t cs,
  input  wire logic [WIDTH-1:0]     prescale_cnt,
  input  wire logic                 external_count_input,
  // tick
  output logic                      timer_tick_clock
);
  import timer0_pkg::*;

  logic ext_prev_r;
  logic ext_prev_nxt;

  // a tap fires once every 2**bits cycles, when its low bits are all ones
  function automatic logic tap(input logic [WIDTH-1:0] c, input int bits);
    logic hit;
    hit = 1'b1;
    for (int i = 0; i < bits; i++) begin
      hit = hit & c[i];
    end
    return hit;
  endfunction

  always_comb begin
    ext_prev_nxt = external_count_input;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_prev_nxt;
    end
  end

  always_comb begin
    unique case (cs)
      CS_STOP:     timer_tick_clock = 1'b0;
      CS_DIV1:     timer_tick_clock = 1'b1;
      CS_DIV8:     timer_tick_clock = tap(prescale_cnt, 3);
      CS_DIV64:    timer_tick_clock = tap(prescale_cnt, 6);
      CS_DIV256:   timer_tick_clock = tap(prescale_cnt, 8);
      CS_DIV1024:  timer_tick_clock = tap(prescale_cnt, 10);
      CS_EXT_FALL: timer_tick_clock = ext_prev_r & ~external_count_input;
      CS_EXT_RISE: timer_tick_clock = ~ext_prev_r & external_count_input;
    endcase
  end
endmodule

/* File: timer0_asserts.sv */
// concurrent checks on the ports of timer0_top
// assumes a single ahb-lite master with hready tied to hreadyout
`timescale 1ns/1ns
module timer0_asserts
  import timer0_pkg::*;
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pins
  input wire logic        compare_output_pin,
  input wire logic        compare_output_en,
  input wire logic        irq,
  input wire logic        count_at_bottom,
  input wire logic        count_at_max
);
  // ==========================================================================
  // shadow of ctrl and mask, rebuilt from observed writes
  logic       wph_r, wph_nxt;
  logic [7:0] wad_r, wad_nxt;
  logic [7:0] ctl_r, ctl_nxt;
  logic [1:0] msk_r, msk_nxt;
  logic       cw;

  assign cw = wph_r && (wad_r == OFS_COUNT);

  always_comb begin
    wph_nxt = hsel & hready & htrans[1] & hwrite;
    wad_nxt = haddr[7:0];
    ctl_nxt = ctl_r;
    msk_nxt = msk_r;
    if (wph_r && wad_r == OFS_CTRL) ctl_nxt = {1'b0, hwdata[6:0]};
    if (wph_r && wad_r == OFS_MASK) msk_nxt = hwdata[1:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph_r <= 1'b0;
      wad_r <= 8'h00;
      ctl_r <= 8'h00;
      msk_r <= 2'h0;
    end else begin
      wph_r <= wph_nxt;
      wad_r <= wad_nxt;
      ctl_r <= ctl_nxt;
      msk_r <= msk_nxt;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ready_ok_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  out_enable_a: assert property (
    compare_output_en == (ctl_r[6:5] != 2'h0))
    else $error("pin enable does not follow com field");
  stop_hold_a: assert property (
    ctl_r[2:0] == CS_STOP && !cw |=>
    $stable(count_at_bottom) && $stable(count_at_max))
    else $error("stopped counter changed");
  wrap_bottom_a: assert property (
    ctl_r[4:0] == 5'h01 && count_at_max && !cw |=> count_at_bottom)
    else $error("no wrap from max to zero");
  tick_count_a: assert property (
    ctl_r[4:0] == 5'h01 && !count_at_max && !cw |=> !count_at_bottom)
    else $error("counter reached zero below max");
  count_write_a: assert property (cw |=>
    count_at_bottom == ($past(hwdata[7:0]) == COUNT_BOT) &&
    count_at_max == ($past(hwdata[7:0]) == COUNT_MAX))
    else $error("count write not applied");
  irq_mask_a: assert property (irq |-> msk_r != 2'h0)
    else $error("interrupt with all requests masked");
  extreme_excl_a: assert property (
    !(count_at_bottom && count_at_max))
    else $error("bottom and max together");

  cover property (count_at_max ##1 count_at_bottom);
  cover property ($rose(irq));
  cover property ($rose(compare_output_pin));
endmodule

bind timer0_top timer0_asserts u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hreadyout(hreadyout), .hresp(hresp),
  .compare_output_pin(compare_output_pin),
  .compare_output_en(compare_output_en), .irq(irq),
  .count_at_bottom(count_at_bottom), .count_at_max(count_at_max));

/* File: test_eight_bit_timer_single_compare.sv */
// self-checking bench for timer0_top, registers reached over ahb-lite
// assumes the slave answers with hreadyout; one master, one slave
`timescale 1ns/1ns
module test_eight_bit_timer_single_compare;
  import timer0_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        ext = 1'b0;
  logic        ack = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, pin, pin_en, irq, bot, max;
  int          err_count = 0;
  int          check_count = 0;

  always #5 hclk = ~hclk;

  timer0_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_count_input(ext),
    .compare_output_pin(pin), .compare_output_en(pin_en),
    .compare_irq_ack(ack), .irq(irq), .count_at_bottom(bot),
    .count_at_max(max));

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one single transfer; read data lands in rd
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // outputs are looked at mid-cycle, where they are settled
  task automatic tick(input int n);
    repeat (n) @(negedge hclk);
  endtask

  task automatic pulse;
    @(posedge hclk) ext <= 1'b1;
    repeat (3) @(posedge hclk);
    ext <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    logic [7:0] a[6] = '{OFS_CTRL, OFS_COUNT, OFS_COMPARE, OFS_FLAGS,
                         OFS_MASK, 8'h14};
    foreach (a[i]) begin
      bus(a[i], 1'b0, 32'h0);
      check(rd, 32'h0);
    end
    check({irq, bot, max, pin_en, pin}, 5'b01000);
    $display("reset values done");
  endtask

  task automatic t_stop;
    bus(OFS_COUNT, 1'b1, 32'h5a);
    tick(20);
    bus(OFS_COUNT, 1'b0, 32'h0);
    check(rd, 32'h5a);
    bus(OFS_COMPARE, 1'b1, 32'h1a5);
    bus(OFS_COMPARE, 1'b0, 32'h0);
    check(rd, 32'ha5);
    bus(8'h14, 1'b1, 32'hff);
    bus(8'h14, 1'b0, 32'h0);
    check(rd, 32'h0);
    $display("stopped counter done");
  endtask

  task automatic t_ovf;
    bus(OFS_CTRL, 1'b1, 32'h01);
    bus(OFS_COUNT, 1'b1, 32'hf0);
    for (int i = 0; i < 40 && max !== 1'b1; i++) tick(1);
    check(max, 1'b1);
    tick(1);
    check(bot, 1'b1);
    bus(OFS_FLAGS, 1'b0, 32'h0);
    check(rd[0], 1'b1);
    tick(1);
    check(irq, 1'b0);
    bus(OFS_MASK, 1'b1, 32'h1);
    tick(1);
    check(irq, 1'b1);
    bus(OFS_FLAGS, 1'b1, 32'h1);
    tick(1);
    check(irq, 1'b0);
    bus(OFS_CTRL, 1'b1, 32'h0);
    bus(OFS_MASK, 1'b1, 32'h0);
    $display("overflow done");
  endtask

  task automatic t_ext;
    bus(OFS_FLAGS, 1'b1, 32'h3);
    bus(OFS_COMPARE, 1'b1, 32'h14);
    bus(OFS_COUNT, 1'b1, 32'h13);
    bus(OFS_CTRL, 1'b1, 32'h07);
    pulse();
    bus(OFS_COUNT, 1'b0, 32'h0);
    check(rd, 32'h14);
    bus(OFS_FLAGS, 1'b0, 32'h0);
    check(rd[1], 1'b0);
    pulse();
    bus(OFS_FLAGS, 1'b0, 32'h0);
    check(rd[1], 1'b1);
    bus(OFS_CTRL, 1'b1, 32'h06);
    repeat (3) pulse();
    bus(OFS_COUNT, 1'b0, 32'h0);
    check(rd, 32'h18);
    bus(OFS_MASK, 1'b1, 32'h2);
    tick(1);
    check(irq, 1'b1);
    @(posedge hclk) ack <= 1'b1;
    @(posedge hclk) ack <= 1'b0;
    tick(1);
    check(irq, 1'b0);
    bus(OFS_CTRL, 1'b1, 32'h0);
    bus(OFS_MASK, 1'b1, 32'h0);
    $display("event input done");
  endtask

  task automatic t_ctc;
    bus(OFS_COUNT, 1'b1, 32'h0);
    bus(OFS_COMPARE, 1'b1, 32'h5);
    bus(OFS_CTRL, 1'b1, 32'h11);
    repeat (6) begin
      bus(OFS_COUNT, 1'b0, 32'h0);
      check(rd <= 32'h5, 1'b1);
    end
    bus(OFS_CTRL, 1'b1, 32'h0);
    $display("clear on compare done");
  endtask

  // bit 8 holds the pin level expected after each forced match
  task automatic t_wave;
    logic [8:0] tb[4] = '{9'h1a0, 9'h0c0, 9'h1e0, 9'h0a0};
    foreach (tb[i]) begin
      bus(OFS_CTRL, 1'b1, {24'h0, tb[i][7:0]});
      tick(2);
      check({pin_en, pin}, {1'b1, tb[i][8]});
    end
    bus(OFS_CTRL, 1'b0, 32'h0);
    check(rd, 32'h20);
    bus(OFS_CTRL, 1'b1, 32'h0);
    tick(1);
    check(pin_en, 1'b0);
    $display("waveform done");
  endtask

  // fast pwm sets the pin at top and clears it at match; a new compare
  // value waits for top; phase pwm overflows only when it turns at zero
  task automatic t_pwm;
    bus(OFS_COMPARE, 1'b1, 32'h40);
    bus(OFS_COUNT, 1'b1, 32'h0);
    bus(OFS_CTRL, 1'b1, 32'h59);
    for (int i = 0; i < 300 && max !== 1'b1; i++) tick(1);
    tick(1);
    check(pin, 1'b1);
    tick(8'h42);
    check(pin, 1'b0);
    bus(OFS_COMPARE, 1'b1, 32'h80);
    for (int i = 0; i < 300 && max !== 1'b1; i++) tick(1);
    tick(8'h42);
    check(pin, 1'b1);
    tick(8'h40);
    check(pin, 1'b0);
    bus(OFS_CTRL, 1'b1, 32'h49);
    bus(OFS_FLAGS, 1'b1, 32'h3);
    for (int i = 0; i < 600 && max !== 1'b1; i++) tick(1);
    tick(1);
    bus(OFS_FLAGS, 1'b0, 32'h0);
    check(rd[0], 1'b0);
    for (int i = 0; i < 300 && bot !== 1'b1; i++) tick(1);
    tick(1);
    bus(OFS_FLAGS, 1'b0, 32'h0);
    check(rd[0], 1'b1);
    check(pin, 1'b1);
    bus(OFS_CTRL, 1'b1, 32'h0);
    $display("pwm modes done");
  endtask

  // each divider runs ten of its periods from a count write, so exactly
  // ten ticks; a wrong tap or prescaler width lands elsewhere
  task automatic t_div;
    int unsigned n[4] = '{8, 64, 256, 1024};
    for (int i = 0; i < 4; i++) begin
      bus(OFS_CTRL, 1'b1, 32'(i + 2));
      bus(OFS_COUNT, 1'b1, 32'h0);
      tick(10 * n[i]);
      bus(OFS_COUNT, 1'b0, 32'h0);
      check(rd, 32'ha);
    end
    bus(OFS_CTRL, 1'b1, 32'h0);
    $display("prescaler done");
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_stop();
    t_ovf();
    t_ext();
    t_ctc();
    t_wave();
    t_pwm();
    t_div();
    end_of_test();
  end

  initial begin
    #300us;
    err_count++;
    end_of_test();
  end
endmodule
